//--- inc/mpvt_pkg.sv
package mpvt_pkg;

  // ----------------------------------------------------------------
  // register map (word index on the register port)
  // ----------------------------------------------------------------
  localparam logic [7:0]  FLOW_IDX        = 8'h08;
  localparam logic [7:0]  TAG1_IDX        = 8'h09;
  localparam logic [7:0]  TAG2_IDX        = 8'h0a;
  localparam logic [31:0] FLOW_RESET      = 32'h0000_0000;
  localparam logic [15:0] TAG_RESET       = 16'h0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int QUANTA_LSB       = 16;
  localparam int QUANTA_MSB       = 31;
  localparam int PASS_CTL_BIT     = 2;
  localparam int FUNC_EN_BIT      = 1;
  localparam int PENDING_BIT      = 0;
  localparam int TAG_MSB          = 15;

  // ----------------------------------------------------------------
  // frame layout and limits
  // ----------------------------------------------------------------
  localparam logic [47:0] PAUSE_DA        = 48'h0180_c200_0001;
  localparam logic [15:0] CTL_TYPE        = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE    = 16'h0001;
  localparam logic [10:0] TYPE_HI_POS     = 11'h00c;
  localparam logic [10:0] TYPE_LO_POS     = 11'h00d;
  localparam logic [10:0] OPC_HI_POS      = 11'h00e;
  localparam logic [10:0] OPC_LO_POS      = 11'h00f;
  localparam logic [10:0] QNT_HI_POS      = 11'h010;
  localparam logic [10:0] QNT_LO_POS      = 11'h011;
  localparam logic [10:0] DA_LAST_POS     = 11'h005;
  localparam logic [10:0] MIN_FRAME_LEN   = 11'h040;
  localparam logic [10:0] MAX_LEN_PLAIN   = 11'd1518;
  localparam logic [10:0] MAX_LEN_VLAN    = 11'd1522;
  localparam logic [10:0] LEN_SATURATE    = 11'h7ff;

  // ----------------------------------------------------------------
  // timing: slot time is 512 bit times, hold-off rounds up
  // ----------------------------------------------------------------
  localparam int CLK_NS           = 100;
  localparam int SLOT_BITS        = 512;
  localparam int BIT_NS_10M       = 100;
  localparam int BIT_NS_100M      = 10;
  localparam int SLOT_CYC_10M     = (SLOT_BITS * BIT_NS_10M + CLK_NS - 1) / CLK_NS;
  localparam int SLOT_CYC_100M    = (SLOT_BITS * BIT_NS_100M + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PTX_IDLE = 2'b00,
    PTX_SEND = 2'b01,
    PTX_WAIT = 2'b11
  } mpvt_ptx_e;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic       crc_ok;
    logic [7:0] data;
  } mpvt_rx_s;

  typedef struct packed {
    logic       done;
    logic       first_tag_register;
    logic       second_tag_register;
    logic       len_err;
    logic       pause;
  } mpvt_rxstat_s;

endpackage

//--- src/mpvt_pause_vlan.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
// What this block does
// - enabled: inspect every received frame for pause
// - valid pause holds transmitter quanta times slot
// - disabled: no control decode, no pause hold-off; pause frames still sent on request
// - pause flow control only in full duplex
// - half duplex: enable bit drives backpressure
// - busy flag bit 0 while pause/backpressure
// - busy clears when pause frame sent
// - bytes 13-14 match first tag: first_tag_register
// - bytes 13-14 match second tag: second_tag_register
// - vlan frames allowed 1522 not 1518
// - tag in bits 15-0, upper reserved
// - pause frame carries register quanta field
// - transmitter disabled: no pause, no backpressure
module mpvt_pause_vlan
(
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  full_duplex,
  input  wire logic                  link_100m,
  input  wire logic                  tx_enable,
  input  wire mpvt_pkg::mpvt_rx_s    rx_in,
  output mpvt_pkg::mpvt_rxstat_s     rx_stat,
  input  wire logic                  pause_send_req,
  output logic                       pause_tx_start,
  output logic      [15:0]           pause_tx_quanta,
  input  wire logic                  pause_tx_done,
  input  wire logic                  backpressure_req,
  output logic                       backpressure,
  output logic                       tx_hold
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] pause_quanta_value_ff;
  logic        pass_ctl_ff;
  logic        pause_function_enable_ff;
  logic [15:0] first_tag_identifier_ff;
  logic [15:0] second_tag_identifier_ff;
  logic [31:0] rdata_ff;
  logic        pause_tx_pending;

  wire wr_flow = reg_wr && (reg_addr == mpvt_pkg::FLOW_IDX);
  wire wr_tag1 = reg_wr && (reg_addr == mpvt_pkg::TAG1_IDX);
  wire wr_tag2 = reg_wr && (reg_addr == mpvt_pkg::TAG2_IDX);

  // busy bit is read-only; whatever is written there is dropped
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pause_quanta_value_ff    <= mpvt_pkg::FLOW_RESET[mpvt_pkg::QUANTA_MSB:mpvt_pkg::QUANTA_LSB];
      pass_ctl_ff              <= mpvt_pkg::FLOW_RESET[mpvt_pkg::PASS_CTL_BIT];
      pause_function_enable_ff <= mpvt_pkg::FLOW_RESET[mpvt_pkg::FUNC_EN_BIT];
    end
    else if (wr_flow)
    begin
      pause_quanta_value_ff    <= reg_wdata[mpvt_pkg::QUANTA_MSB:mpvt_pkg::QUANTA_LSB];
      pass_ctl_ff              <= reg_wdata[mpvt_pkg::PASS_CTL_BIT];
      pause_function_enable_ff <= reg_wdata[mpvt_pkg::FUNC_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      first_tag_identifier_ff  <= mpvt_pkg::TAG_RESET;
      second_tag_identifier_ff <= mpvt_pkg::TAG_RESET;
    end
    else
    begin
      if (wr_tag1)
        first_tag_identifier_ff  <= reg_wdata[mpvt_pkg::TAG_MSB:0];
      if (wr_tag2)
        second_tag_identifier_ff <= reg_wdata[mpvt_pkg::TAG_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  // read data valid only in the cycle after the strobe
  logic [31:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        mpvt_pkg::FLOW_IDX:
        begin
          nxt_rdata[mpvt_pkg::QUANTA_MSB:mpvt_pkg::QUANTA_LSB] = pause_quanta_value_ff;
          nxt_rdata[mpvt_pkg::PASS_CTL_BIT] = pass_ctl_ff;
          nxt_rdata[mpvt_pkg::FUNC_EN_BIT]  = pause_function_enable_ff;
          nxt_rdata[mpvt_pkg::PENDING_BIT]  = pause_tx_pending;
        end
        mpvt_pkg::TAG1_IDX: nxt_rdata[mpvt_pkg::TAG_MSB:0] = first_tag_identifier_ff;
        mpvt_pkg::TAG2_IDX: nxt_rdata[mpvt_pkg::TAG_MSB:0] = second_tag_identifier_ff;
        default:            nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rdata_ff <= 32'h0000_0000;
    else
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // receive parser
  // ----------------------------------------------------------------
  function automatic logic tag_hit(input logic [7:0] hi, input logic [7:0] lo,
                                   input logic [15:0] tag);
    tag_hit = ({hi, lo} == tag);
  endfunction

  logic [10:0] cnt_ff;
  logic [7:0]  hi_byte_ff;
  logic        da_ok_ff;
  logic        ctl_type_ff;
  logic        opc_ok_ff;
  logic        first_tag_register_ff;
  logic        second_tag_register_ff;
  logic [15:0] rx_quanta_ff;
  mpvt_pkg::mpvt_rxstat_s stat_ff;

  wire        ctl_decode = pause_function_enable_ff && full_duplex;
  wire [10:0] pos        = rx_in.sof ? 11'h000 : cnt_ff;
  wire [10:0] len        = (pos == mpvt_pkg::LEN_SATURATE) ? pos : pos + 11'h001;
  wire        at_type    = rx_in.valid && (pos == mpvt_pkg::TYPE_LO_POS);
  wire        hit1       = at_type && tag_hit(hi_byte_ff, rx_in.data, first_tag_identifier_ff);
  wire        hit2       = at_type && tag_hit(hi_byte_ff, rx_in.data, second_tag_identifier_ff);
  wire        is_first_tag_register   = (first_tag_register_ff && !rx_in.sof) || hit1;
  wire        is_second_tag_register   = (second_tag_register_ff && !rx_in.sof) || hit2;
  wire [10:0] max_len    = (is_first_tag_register || is_second_tag_register) ? mpvt_pkg::MAX_LEN_VLAN
                                                  : mpvt_pkg::MAX_LEN_PLAIN;
  wire        da_byte_ok = (rx_in.data == mpvt_pkg::PAUSE_DA[8'd47 - {pos[4:0], 3'b000} -: 8]);
  wire        da_ok_now  = (pos > mpvt_pkg::DA_LAST_POS) ? (da_ok_ff && !rx_in.sof)
                                                         : ((da_ok_ff || rx_in.sof) && da_byte_ok);
  wire        frame_end  = rx_in.valid && rx_in.eof;
  wire        pause_ok   = frame_end && ctl_decode && rx_in.crc_ok && da_ok_ff && ctl_type_ff
                           && opc_ok_ff && (len >= mpvt_pkg::MIN_FRAME_LEN)
                           && (len <= max_len);

  // length saturates so an oversize frame never wraps back into range
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      cnt_ff <= 11'h000;
    else if (rx_in.valid)
      cnt_ff <= frame_end ? 11'h000 : len;
  end

  // a tag hit at the type byte is held until the next frame start
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      hi_byte_ff <= 8'h00;
      da_ok_ff   <= 1'b0;
      first_tag_register_ff   <= 1'b0;
      second_tag_register_ff   <= 1'b0;
    end
    else if (rx_in.valid)
    begin
      hi_byte_ff <= rx_in.data;
      da_ok_ff   <= da_ok_now;
      first_tag_register_ff   <= is_first_tag_register;
      second_tag_register_ff   <= is_second_tag_register;
    end
  end

  // control fields only decoded when the function is enabled
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctl_type_ff  <= 1'b0;
      opc_ok_ff    <= 1'b0;
      rx_quanta_ff <= 16'h0000;
    end
    else if (rx_in.valid)
    begin
      if (rx_in.sof)
      begin
        ctl_type_ff <= 1'b0;
        opc_ok_ff   <= 1'b0;
      end
      else if (ctl_decode)
      begin
        if (pos == mpvt_pkg::TYPE_LO_POS)
          ctl_type_ff <= tag_hit(hi_byte_ff, rx_in.data, mpvt_pkg::CTL_TYPE);
        if (pos == mpvt_pkg::OPC_LO_POS)
          opc_ok_ff   <= tag_hit(hi_byte_ff, rx_in.data, mpvt_pkg::PAUSE_OPCODE);
        if (pos == mpvt_pkg::QNT_HI_POS)
          rx_quanta_ff[15:8] <= rx_in.data;
        if (pos == mpvt_pkg::QNT_LO_POS)
          rx_quanta_ff[7:0]  <= rx_in.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // status pulses
  // ----------------------------------------------------------------
  // pulses last one cycle; whoever needs them must catch them then
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      stat_ff <= '0;
    else
    begin
      stat_ff.done    <= frame_end;
      stat_ff.first_tag_register   <= frame_end && is_first_tag_register;
      stat_ff.second_tag_register   <= frame_end && is_second_tag_register;
      stat_ff.len_err <= frame_end && (len > max_len);
      stat_ff.pause   <= pause_ok;
    end
  end

  assign rx_stat = stat_ff;

  // ----------------------------------------------------------------
  // transmit hold-off
  // ----------------------------------------------------------------
  localparam logic [9:0] SLOT_LAST_10M  = 10'(mpvt_pkg::SLOT_CYC_10M - 1);
  localparam logic [9:0] SLOT_LAST_100M = 10'(mpvt_pkg::SLOT_CYC_100M - 1);

  logic [15:0] quanta_left_ff;
  logic [9:0]  slot_cnt_ff;
  wire  [9:0]  slot_last = link_100m ? SLOT_LAST_100M : SLOT_LAST_10M;

  // a fresh pause frame restarts the wait from its own value
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      quanta_left_ff <= 16'h0000;
      slot_cnt_ff    <= 10'h000;
    end
    // decode switched off ends a running hold-off at once
    else if (!ctl_decode)
    begin
      quanta_left_ff <= 16'h0000;
      slot_cnt_ff    <= 10'h000;
    end
    else if (stat_ff.pause)
    begin
      quanta_left_ff <= rx_quanta_ff;
      slot_cnt_ff    <= 10'h000;
    end
    else if (quanta_left_ff != 16'h0000)
    begin
      if (slot_cnt_ff >= slot_last)
      begin
        slot_cnt_ff    <= 10'h000;
        quanta_left_ff <= quanta_left_ff - 16'h0001;
      end
      else
        slot_cnt_ff <= slot_cnt_ff + 10'h001;
    end
  end

  assign tx_hold = (quanta_left_ff != 16'h0000);

  // ----------------------------------------------------------------
  // pause frame transmit and backpressure
  // ----------------------------------------------------------------
  mpvt_pkg::mpvt_ptx_e ptx_ff;
  mpvt_pkg::mpvt_ptx_e nxt_ptx;
  logic                bp_ff;
  logic [15:0]         tx_quanta_ff;

  always_comb
  begin
    nxt_ptx = ptx_ff;
    case (ptx_ff)
      mpvt_pkg::PTX_IDLE:
        if (pause_send_req && full_duplex && tx_enable)
          nxt_ptx = mpvt_pkg::PTX_SEND;
      mpvt_pkg::PTX_SEND:
        nxt_ptx = mpvt_pkg::PTX_WAIT;
      // done seen in any other state is ignored
      mpvt_pkg::PTX_WAIT:
        if (pause_tx_done)
          nxt_ptx = mpvt_pkg::PTX_IDLE;
      default:
        nxt_ptx = mpvt_pkg::PTX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      ptx_ff <= mpvt_pkg::PTX_IDLE;
    else
      ptx_ff <= nxt_ptx;
  end

  // quanta latched at start so a late register write cannot tear the frame
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      tx_quanta_ff <= 16'h0000;
    else if (ptx_ff == mpvt_pkg::PTX_IDLE)
      tx_quanta_ff <= pause_quanta_value_ff;
  end

  // ----------------------------------------------------------------
  // backpressure
  // ----------------------------------------------------------------
  // one cycle behind its request; no minimum assertion time
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      bp_ff <= 1'b0;
    else
      bp_ff <= backpressure_req && pause_function_enable_ff
               && !full_duplex && tx_enable;
  end

  assign pause_tx_start   = (ptx_ff == mpvt_pkg::PTX_SEND);
  assign pause_tx_quanta  = tx_quanta_ff;
  assign backpressure     = bp_ff;
  assign pause_tx_pending = (ptx_ff != mpvt_pkg::PTX_IDLE) || bp_ff;

endmodule

//--- testbench/mpvt_pause_vlan_asserts.sv
`timescale 1ns/1ns
module mpvt_pause_vlan_asserts
(
  input wire logic                   sys_clk,
  input wire logic                   sys_rst,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata,
  input wire logic                   full_duplex,
  input wire logic                   tx_enable,
  input wire mpvt_pkg::mpvt_rx_s     rx_in,
  input wire mpvt_pkg::mpvt_rxstat_s rx_stat,
  input wire logic                   pause_tx_start,
  input wire logic                   backpressure_req,
  input wire logic                   backpressure,
  input wire logic                   tx_hold
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ----
  // port relations
  // ----
  a_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_bp_cause: assert property (backpressure |-> $past(backpressure_req && !full_duplex && tx_enable))
    else $error("backpressure without cause");
  a_start_cause: assert property (pause_tx_start |-> $past(full_duplex && tx_enable))
    else $error("pause start without full duplex tx");
  a_start_pulse: assert property (pause_tx_start |=> !pause_tx_start)
    else $error("pause start longer than one cycle");
  a_pause_done: assert property (rx_stat.pause |-> rx_stat.done)
    else $error("pause flag without done");
  a_vlan_done: assert property ((rx_stat.first_tag_register || rx_stat.second_tag_register) |-> rx_stat.done)
    else $error("tag flag without done");
  a_done_eof: assert property (rx_stat.done |-> $past(rx_in.valid && rx_in.eof))
    else $error("status without frame end");
  a_hold_cause: assert property ($rose(tx_hold) |-> $past(rx_stat.pause) || $past(rx_stat.pause, 2))
    else $error("hold-off without pause frame");
  a_hold_half: assert property (!full_duplex |=> !tx_hold)
    else $error("hold-off in half duplex");
  c_pause: cover property (rx_stat.pause);
  c_vlan: cover property (rx_stat.first_tag_register && !rx_stat.len_err);
  c_bp: cover property (backpressure);
endmodule
bind mpvt_pause_vlan mpvt_pause_vlan_asserts u_chk (.sys_clk, .sys_rst, .reg_rd, .reg_rdata,
  .full_duplex, .tx_enable, .rx_in, .rx_stat, .pause_tx_start, .backpressure_req,
  .backpressure, .tx_hold);

//--- testbench/mpvt_pause_vlan_tb_top.sv
`timescale 1ns/1ns
module mpvt_pause_vlan_tb_top;
  logic                   sys_clk = 1'b0;
  logic                   sys_rst = 1'b1;
  logic [7:0]             reg_addr = 8'h00;
  logic [31:0]            reg_wdata = 32'h0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [31:0]            reg_rdata;
  logic                   full_duplex = 1'b1;
  logic                   tx_enable = 1'b1;
  mpvt_pkg::mpvt_rx_s     rx_in = '0;
  mpvt_pkg::mpvt_rxstat_s rx_stat;
  logic                   pause_send_req = 1'b0;
  logic                   backpressure_req = 1'b0;
  logic                   pause_tx_start;
  logic                   pause_tx_done;
  logic [15:0]            pause_tx_quanta;
  logic                   backpressure;
  logic                   tx_hold;
  logic                   rd_d = 1'b0;
  logic                   link_100m = 1'b1;
  int                     n_mismatch = 0;
  int                     num_checks = 0;
  int                     seed = 7354;
  logic [31:0]            rq[$];
  logic [4:0]             fq[$];
  localparam logic [15:0] CTL = mpvt_pkg::CTL_TYPE;
  always #50 sys_clk = ~sys_clk;
  mpvt_pause_vlan uut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .full_duplex, .link_100m, .tx_enable, .rx_in, .rx_stat,
    .pause_send_req, .pause_tx_start, .pause_tx_quanta, .pause_tx_done,
    .backpressure_req, .backpressure, .tx_hold);
  mpvt_tx_model #(.DLY(6)) u_txm (.sys_clk, .sys_rst, .pause_tx_start, .pause_tx_done);
  // ----
  // checking and bus tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  // expected flags: done, first_tag_register, second_tag_register, len_err, pause
  task automatic frame(input int n, input logic [15:0] ty, input logic [15:0] q,
                       input logic [4:0] e);
    logic [7:0] b;
    fq.push_back(e);
    for (int i = 0; i < n; i++)
    begin
      b = 8'($random(seed));
      case (i)
        0, 1, 2, 3, 4, 5: if (ty == CTL) b = mpvt_pkg::PAUSE_DA[47 - 8 * i -: 8];
        12: b = ty[15:8];
        13: b = ty[7:0];
        14: b = 8'h00;
        15: b = 8'h01;
        16: b = q[15:8];
        17: b = q[7:0];
        default: ;
      endcase
      @(posedge sys_clk);
      rx_in <= {1'b1, i == 0, i == n - 1, 1'b1, b};
    end
    @(posedge sys_clk);
    rx_in <= '0;
  endtask
  // results are compared as they appear, against the oldest note
  always @(posedge sys_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      chk(reg_rdata, rq.pop_front());
    if (rx_stat.done === 1'b1)
      chk(32'(rx_stat), 32'(fq.pop_front()));
  end
  initial
  begin
    #3_000_000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h08, 32'h0);
    rd(8'h09, 32'h0);
    rd(8'h0a, 32'h0);
    rd(8'h0b, 32'h0);
    wr(mpvt_pkg::TAG1_IDX, 32'hffff_8100);
    wr(mpvt_pkg::TAG2_IDX, 32'hffff_8100);
    rd(mpvt_pkg::TAG1_IDX, 32'h0000_8100);
    rd(mpvt_pkg::TAG2_IDX, 32'h0000_8100);
    wr(mpvt_pkg::TAG2_IDX, 32'h0000_0000);
    wr(mpvt_pkg::FLOW_IDX, 32'h0002_0002);
    rd(mpvt_pkg::FLOW_IDX, 32'h0002_0002);
    frame(1522, 16'h8100, 16'h0, 5'b11000);
    frame(1523, 16'h8100, 16'h0, 5'b11010);
    frame(1519, 16'h0800, 16'h0, 5'b10010);
    wr(mpvt_pkg::TAG1_IDX, 32'h0000_0000);
    wr(mpvt_pkg::TAG2_IDX, 32'h0000_8100);
    frame(1518, 16'h8100, 16'h0, 5'b10100);
    frame(64, CTL, 16'h0002, 5'b10001);
    repeat (50) @(negedge sys_clk);
    chk(32'(tx_hold), 32'h1);
    repeat (60) @(negedge sys_clk);
    chk(32'(tx_hold), 32'h0);
    @(posedge sys_clk);
    link_100m <= 1'b0;
    frame(64, CTL, 16'h0001, 5'b10001);
    repeat (500) @(negedge sys_clk);
    chk(32'(tx_hold), 32'h1);
    repeat (20) @(negedge sys_clk);
    chk(32'(tx_hold), 32'h0);
    rd(mpvt_pkg::FLOW_IDX, 32'h0002_0002);
    wr(mpvt_pkg::FLOW_IDX, 32'h0002_0000);
    frame(64, CTL, 16'h0002, 5'b10000);
    rd(mpvt_pkg::FLOW_IDX, 32'h0002_0000);
    wr(mpvt_pkg::FLOW_IDX, 32'h0002_0002);
    full_duplex <= 1'b0;
    frame(64, CTL, 16'h0002, 5'b10000);
    backpressure_req <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(32'(backpressure), 32'h1);
    rd(mpvt_pkg::FLOW_IDX, 32'h0002_0003);
    tx_enable <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(32'(backpressure), 32'h0);
    rd(mpvt_pkg::FLOW_IDX, 32'h0002_0002);
    backpressure_req <= 1'b0;
    tx_enable <= 1'b1;
    full_duplex <= 1'b1;
    wr(mpvt_pkg::FLOW_IDX, 32'h1234_0002);
    pause_send_req <= 1'b1;
    @(posedge sys_clk);
    pause_send_req <= 1'b0;
    for (int k = 0; k < 8 && pause_tx_start !== 1'b1; k++) @(negedge sys_clk);
    chk(32'(pause_tx_start), 32'h1);
    chk(32'(pause_tx_quanta), 32'h1234);
    rd(mpvt_pkg::FLOW_IDX, 32'h1234_0003);
    repeat (10) @(posedge sys_clk);
    rd(mpvt_pkg::FLOW_IDX, 32'h1234_0002);
    repeat (4) @(posedge sys_clk);
    chk(32'(rq.size() + fq.size()), 32'h0);
    close_out();
  end
endmodule

//--- testbench/mpvt_tx_model.sv
`timescale 1ns/1ns
// ----
// far-side transmitter: finishes a pause frame DLY cycles after start
// ----
module mpvt_tx_model
#(
  parameter int DLY = 6
)
(
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic pause_tx_start,
  output logic      pause_tx_done
);
  logic [7:0] cnt_ff;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      cnt_ff <= 8'h00;
    else if (pause_tx_start)
      cnt_ff <= 8'(DLY);
    else if (cnt_ff != 8'h00)
      cnt_ff <= cnt_ff - 8'h01;
  end
  assign pause_tx_done = (cnt_ff == 8'h01);
endmodule
